// *** rtl/llt_pkg.sv ***
package llt_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  LLT_THRESH_OFFSET = 8'h02;
  localparam logic [15:0] LLT_THRESH_RESET  = 16'h0000;
  localparam int          LLT_EXP_MSB       = 15;
  localparam int          LLT_EXP_LSB       = 12;
  localparam int          LLT_MANT_MSB      = 11;
  localparam int          LLT_MANT_LSB      = 0;
  localparam int          LLT_EXP_W         = 4;
  localparam int          LLT_MANT_W        = 12;

  // ****************************************
  // Lux scale, counted in units of 0.01 lux
  // ****************************************
  localparam logic [3:0]  LLT_MAX_EXP       = 4'hB;
  localparam int          LLT_LUX_W         = 27;
  localparam logic [26:0] LLT_FULL_SCALE_CL = 27'h07FF800;
  localparam int          LLT_SCALE_LATENCY = 1;

endpackage : llt_pkg

// *** rtl/llt_lux_scale.sv ***
`timescale 1ns/1ps
`default_nettype none
module llt_lux_scale
  import llt_pkg::*;
#(
  parameter int EXP_W  = LLT_EXP_W,
  parameter int MANT_W = LLT_MANT_W,
  parameter int LUX_W  = LLT_LUX_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              in_valid,
  input  wire logic [EXP_W-1:0]  exponent,
  input  wire logic [MANT_W-1:0] mantissa,
  output var  logic              out_valid,
  output var  logic              in_range,
  output var  logic [LUX_W-1:0]  lux
);

  // ****************************************
  // Elaboration check
  // ****************************************
  // Too narrow a result would silently drop high lux bits
  if (LUX_W < MANT_W + (1 << EXP_W) - 1) begin : g_bad_width
    $error("llt_lux_scale: LUX_W too small for the largest exponent");
  end

  logic              out_valid_reg;
  logic              out_valid_next;
  logic              in_range_reg;
  logic              in_range_next;
  logic [LUX_W-1:0]  lux_reg;
  logic [LUX_W-1:0]  lux_next;

  // ****************************************
  // Mantissa shifted by exponent, in 0.01 lux
  // ****************************************
  always_comb begin
    out_valid_next = in_valid;
    in_range_next  = in_range_reg;
    lux_next       = lux_reg;
    if (in_valid) begin
      lux_next      = LUX_W'(mantissa) << exponent;
      in_range_next = (exponent <= EXP_W'(LLT_MAX_EXP));
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid_reg <= 1'b0;
      in_range_reg  <= 1'b0;
      lux_reg       <= '0;
    end else begin
      out_valid_reg <= out_valid_next;
      in_range_reg  <= in_range_next;
      lux_reg       <= lux_next;
    end
  end

  assign out_valid = out_valid_reg;
  assign in_range  = in_range_reg;
  assign lux       = lux_reg;

endmodule : llt_lux_scale
`default_nettype wire

// *** rtl/llt_threshold.sv ***
`timescale 1ns/1ps
`default_nettype none
module llt_threshold
  import llt_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  thresh_wr_en,
  input  wire logic [15:0]           thresh_wr_data,
  input  wire logic                  result_valid,
  input  wire logic [LLT_EXP_W-1:0]  result_exponent,
  input  wire logic [LLT_MANT_W-1:0] result_mantissa,
  output var  logic [15:0]           thresh_rd_data,
  output var  logic [LLT_EXP_W-1:0]  low_thresh_exponent,
  output var  logic [LLT_MANT_W-1:0] low_thresh_mantissa,
  output var  logic [LLT_LUX_W-1:0]  thresh_lux,
  output var  logic                  thresh_defined,
  output var  logic [LLT_LUX_W-1:0]  result_lux,
  output var  logic                  cmp_valid,
  output var  logic                  result_below_low
);

  // ****************************************
  // Threshold register
  // ****************************************
  logic [15:0] thresh_reg;
  logic [15:0] thresh_next;

  always_comb begin
    thresh_next = thresh_reg;
    if (thresh_wr_en) begin
      thresh_next[LLT_EXP_MSB:LLT_EXP_LSB]   = thresh_wr_data[LLT_EXP_MSB:LLT_EXP_LSB];
      thresh_next[LLT_MANT_MSB:LLT_MANT_LSB] = thresh_wr_data[LLT_MANT_MSB:LLT_MANT_LSB];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      thresh_reg <= LLT_THRESH_RESET;
    end else begin
      thresh_reg <= thresh_next;
    end
  end

  // Lower limit fields taken straight from the register; the flag logic sees them one cycle later through u_thresh_scale
  assign thresh_rd_data      = thresh_reg;
  assign low_thresh_exponent = thresh_reg[LLT_EXP_MSB:LLT_EXP_LSB];
  assign low_thresh_mantissa = thresh_reg[LLT_MANT_MSB:LLT_MANT_LSB];

  // ****************************************
  // Both sides scaled by two instances of the same converter
  // ****************************************
  // One shared coding keeps threshold and result on one lux scale
  logic t_valid;
  logic r_valid;
  logic r_in_range;

  llt_lux_scale u_thresh_scale (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (1'b1),
    .exponent  (low_thresh_exponent),
    .mantissa  (low_thresh_mantissa),
    .out_valid (t_valid),
    .in_range  (thresh_defined),
    .lux       (thresh_lux)
  );

  llt_lux_scale u_result_scale (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (result_valid),
    .exponent  (result_exponent),
    .mantissa  (result_mantissa),
    .out_valid (r_valid),
    .in_range  (r_in_range),
    .lux       (result_lux)
  );

  // ****************************************
  // Comparison in lux
  // ****************************************
  logic cmp_valid_reg;
  logic cmp_valid_next;
  logic below_reg;
  logic below_next;

  always_comb begin
    cmp_valid_next = r_valid;
    below_next     = below_reg;
    if (r_valid) begin
      // Reserved exponents never report below; no defined limit exists
      below_next = t_valid && thresh_defined && r_in_range
                   && (result_lux < thresh_lux);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp_valid_reg <= 1'b0;
      below_reg     <= 1'b0;
    end else begin
      cmp_valid_reg <= cmp_valid_next;
      below_reg     <= below_next;
    end
  end

  assign cmp_valid        = cmp_valid_reg;
  assign result_below_low = below_reg;

  // ****************************************
  // Assertions
  // ****************************************
  logic [LLT_LUX_W-1:0] thresh_scaled_chk;
  logic [LLT_LUX_W-1:0] result_scaled_chk;

  assign thresh_scaled_chk = LLT_LUX_W'(low_thresh_mantissa) << low_thresh_exponent;
  assign result_scaled_chk = LLT_LUX_W'(result_mantissa) << result_exponent;

  a_exp_write: assert property (
    @(posedge clk) disable iff (reset)
    thresh_wr_en |=> low_thresh_exponent == $past(thresh_wr_data[15:12]))
    else $error("exponent field did not take the written value");

  a_mant_write: assert property (
    @(posedge clk) disable iff (reset)
    thresh_wr_en |=> low_thresh_mantissa == $past(thresh_wr_data[11:0]))
    else $error("mantissa field did not take the written value");

  a_thresh_hold: assert property (
    @(posedge clk) disable iff (reset)
    !thresh_wr_en |=> $stable(thresh_rd_data))
    else $error("threshold changed without a write");

  a_thresh_scale: assert property (
    @(posedge clk) disable iff (reset)
    thresh_wr_en ##1 !thresh_wr_en |=> thresh_lux == $past(thresh_scaled_chk))
    else $error("threshold lux is not mantissa times two to the exponent");

  a_level_defined: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> thresh_defined == ($past(low_thresh_exponent) <= LLT_MAX_EXP))
    else $error("defined flag disagrees with exponent level");

  a_full_scale: assert property (
    @(posedge clk) disable iff (reset)
    (low_thresh_exponent == 4'hB && low_thresh_mantissa == 12'hFFF)
    |=> thresh_lux == LLT_FULL_SCALE_CL)
    else $error("top level full scale is wrong");

  a_same_scale: assert property (
    @(posedge clk) disable iff (reset)
    result_valid |=> result_lux == $past(result_scaled_chk))
    else $error("result not scaled like the threshold");

  a_cmp_latency: assert property (
    @(posedge clk) disable iff (reset)
    result_valid |=> ##1 cmp_valid)
    else $error("comparison not reported two cycles after result");

  a_cmp_value: assert property (
    @(posedge clk) disable iff (reset)
    (cmp_valid && $past(thresh_defined) && $past(r_in_range))
    |-> result_below_low == ($past(result_lux) < $past(thresh_lux)))
    else $error("below flag disagrees with lux comparison");

  a_cmp_reserved: assert property (
    @(posedge clk) disable iff (reset)
    (cmp_valid && !$past(thresh_defined)) |-> !result_below_low)
    else $error("reserved threshold exponent reported below");

  // Reset checks carry no disable so they see the reset itself
  a_reset_clear: assert property (
    @(posedge clk)
    reset |-> thresh_rd_data == LLT_THRESH_RESET)
    else $error("threshold register not cleared by reset");

  a_reset_quiet: assert property (
    @(posedge clk)
    reset |-> !cmp_valid && !result_below_low)
    else $error("comparison outputs not cleared by reset");

  a_thresh_track: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> thresh_lux == $past(thresh_scaled_chk))
    else $error("threshold lux does not follow the register");

  a_lsb_step: assert property (
    @(posedge clk) disable iff (reset)
    low_thresh_mantissa == 12'h001
    |=> thresh_lux == (27'h0000001 << $past(low_thresh_exponent)))
    else $error("one mantissa step is not two to the exponent");

  a_defined_high: assert property (
    @(posedge clk) disable iff (reset)
    low_thresh_exponent > LLT_MAX_EXP |=> !thresh_defined)
    else $error("reserved exponent reported as a defined level");

  a_result_hold: assert property (
    @(posedge clk) disable iff (reset)
    !result_valid |=> $stable(result_lux))
    else $error("result lux changed without a new result");

  a_cmp_pulse: assert property (
    @(posedge clk) disable iff (reset)
    !r_valid |=> !cmp_valid)
    else $error("comparison reported without a scaled result");

  a_below_hold: assert property (
    @(posedge clk) disable iff (reset)
    !cmp_valid |-> $stable(result_below_low))
    else $error("below flag changed outside a comparison");

  a_cmp_equal: assert property (
    @(posedge clk) disable iff (reset)
    (cmp_valid && $past(result_lux) == $past(thresh_lux)) |-> !result_below_low)
    else $error("equal result and limit reported below");

  a_result_reserved: assert property (
    @(posedge clk) disable iff (reset)
    (cmp_valid && !$past(r_in_range)) |-> !result_below_low)
    else $error("reserved result exponent reported below");

endmodule : llt_threshold
`default_nettype wire

// *** tb/llt_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module llt_host_model
  import llt_pkg::*;
(
  input  wire logic        clk,
  output var  logic        wr_en,
  output var  logic [15:0] wr_data
);
  initial begin
    wr_en   <= 1'b0;
    wr_data <= 16'hFFFF;
  end
  // Word goes out whole; data inverted once released so stale bits never match
  task automatic write_word(input logic [3:0] e, input logic [11:0] m);
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_data <= {e, m};
    @(posedge clk);
    wr_en   <= 1'b0;
    wr_data <= ~{e, m};
  endtask : write_word
endmodule : llt_host_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
  import llt_pkg::*;
;
  logic        clk, reset, wr_en, rv, cmp_valid, below, defd;
  logic [15:0] wr_data, rd_data;
  logic [3:0]  r_exp, t_exp;
  logic [11:0] r_mant, t_mant;
  logic [26:0] t_lux, r_lux;
  int          n_errors, tests_run, cycles;

  llt_host_model llt_host_model_inst (.clk(clk), .wr_en(wr_en), .wr_data(wr_data));
  llt_threshold llt_threshold_inst (
    .clk(clk), .reset(reset), .thresh_wr_en(wr_en), .thresh_wr_data(wr_data),
    .result_valid(rv), .result_exponent(r_exp), .result_mantissa(r_mant),
    .thresh_rd_data(rd_data), .low_thresh_exponent(t_exp), .low_thresh_mantissa(t_mant),
    .thresh_lux(t_lux), .thresh_defined(defd), .result_lux(r_lux),
    .cmp_valid(cmp_valid), .result_below_low(below));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [26:0] got, input logic [26:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic wr_check(input logic [3:0] e, input logic [11:0] m, input logic d);
    llt_host_model_inst.write_word(e, m);
    #1;
    chk(27'(rd_data), 27'({e, m}));
    chk(27'({t_exp, t_mant}), 27'({e, m}));
    @(posedge clk);
    #1;
    chk(t_lux, {15'h0, m} << e);
    chk(27'(defd), 27'(d));
  endtask : wr_check

  task automatic send_result(input logic [3:0] e, input logic [11:0] m, input logic b);
    @(posedge clk);
    rv     <= 1'b1;
    r_exp  <= e;
    r_mant <= m;
    @(posedge clk);
    rv     <= 1'b0;
    r_exp  <= ~e;
    r_mant <= ~m;
    #1;
    chk(r_lux, {15'h0, m} << e);
    @(posedge clk);
    #1;
    chk(27'(cmp_valid), 27'h1);
    chk(27'(below), 27'(b));
    @(posedge clk);
    #1;
    chk(27'(cmp_valid), 27'h0);
  endtask : send_result

  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Whole sequence needs about 77 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    reset  <= 1'b1;
    rv     <= 1'b0;
    r_exp  <= 4'h0;
    r_mant <= 12'h000;
    repeat (8) @(posedge clk);
    chk(27'(rd_data), 27'h0);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(27'(defd), 27'h1);
    for (int e = 0; e < 12; e++) wr_check(4'(e), 12'hFFF, 1'b1);
    wr_check(4'h5, 12'h000, 1'b1);
    wr_check(4'hC, 12'h123, 1'b0);
    send_result(4'h0, 12'h001, 1'b0);
    wr_check(4'h2, 12'h100, 1'b1);
    send_result(4'h0, 12'h3FF, 1'b1);
    send_result(4'h1, 12'h200, 1'b0);
    send_result(4'h3, 12'h07F, 1'b1);
    send_result(4'hC, 12'h000, 1'b0);
    wr_check(4'hB, 12'h001, 1'b1);
    summarize();
  end
endmodule : testbench
`default_nettype wire
